// File: rtl/tcc_pkg.sv
// Package for the timer compare/capture unit: register offsets, field
// positions, reset values, clock select codes and carrier structs.
// Assumes an 8-bit register port with byte addresses.
package tcc_pkg;

  localparam int CNT_W = 16;
  localparam int REG_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_CAP1_HI  = 8'hF0;
  localparam logic [7:0] OFS_CAP1_LO  = 8'hF1;
  localparam logic [7:0] OFS_CAP2_HI  = 8'hF2;
  localparam logic [7:0] OFS_CAP2_LO  = 8'hF3;
  localparam logic [7:0] OFS_CMP1_HI  = 8'hF4;
  localparam logic [7:0] OFS_CMP1_LO  = 8'hF5;
  localparam logic [7:0] OFS_CMP2_HI  = 8'hF6;
  localparam logic [7:0] OFS_CMP2_LO  = 8'hF7;
  localparam logic [7:0] OFS_CNT_HI   = 8'hF8;
  localparam logic [7:0] OFS_CNT_LO   = 8'hF9;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'hFA;
  localparam logic [7:0] OFS_CTRL3    = 8'hFB;
  localparam logic [7:0] OFS_EV_STAT  = 8'hFC;
  localparam logic [7:0] OFS_EV_MASK  = 8'hFD;
  localparam logic [7:0] OFS_STATUS   = 8'hFE;

  // timer_flag_status bit positions
  localparam int FLAG_CAP1 = 7;
  localparam int FLAG_CMP1 = 6;
  localparam int FLAG_OVF  = 5;
  localparam int FLAG_CAP2 = 4;
  localparam int FLAG_CMP2 = 3;

  // Event status / mask bit positions
  localparam int EV_CMP1 = 0;
  localparam int EV_CMP2 = 1;
  localparam int EV_CAP1 = 2;
  localparam int EV_CAP2 = 3;
  localparam int EV_OVF  = 4;
  localparam int EV_W    = 5;

  // Flags sharing the read-status-then-access clearing scheme
  localparam int SF_CAP1 = 0;
  localparam int SF_CAP2 = 1;
  localparam int SF_OVF  = 2;
  localparam int SF_N    = 3;

  // Reset values and counter maximum
  localparam logic [7:0]       STATUS_RST = 8'h00;
  localparam logic [7:0]       CTRL_RST   = 8'h00;
  localparam logic [EV_W-1:0]  EV_RST     = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RST    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;

  // Prescaler tap masks
  localparam logic [2:0] PRE_MASK_DIV2 = 3'h1;
  localparam logic [2:0] PRE_MASK_DIV4 = 3'h3;
  localparam logic [2:0] PRE_MASK_DIV8 = 3'h7;

  typedef enum logic [1:0] {
    CLK_DIV4 = 2'b00,
    CLK_DIV2 = 2'b01,
    CLK_DIV8 = 2'b10,
    CLK_EXT  = 2'b11
  } clk_sel_t;

  typedef struct packed {
    logic common_compare_irq_enable;
    logic channel1_compare_irq_enable;
    logic channel2_compare_irq_enable;
    logic timer_global_irq_enable;
    logic pin_enable1;
    logic pin_enable2;
    logic output_level1;
    logic output_level2;
  } irq_ctrl_t;

  typedef struct packed {
    logic [2:0] spare;
    logic       capture1_edge_select;
    clk_sel_t   timer_clock_select;
    logic       capture2_edge_select;
    logic       ext_clock_edge_select;
  } ctrl3_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// File: rtl/compare_channel.sv
// One output compare channel: compare value, match, flag, request, pin.
// Assumes the counter tick and the next counter value from the parent.
`timescale 1ns/1ps
module compare_channel import tcc_pkg::*; #(
  parameter int W = CNT_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Counter
  input  wire logic         tick,
  input  wire logic [W-1:0] count_next,
  // Software accesses
  input  wire logic         wr_high,
  input  wire logic         wr_low,
  input  wire logic         acc_low,
  input  wire logic         status_rd,
  input  wire logic         status_acc,
  input  wire logic [7:0]   wdata,
  // Control
  input  wire logic         level,
  input  wire logic         pin_en,
  // Results
  output logic [W-1:0]      value,
  output logic              flag,
  output logic              pending,
  output logic              match,
  output logic              pin_out,
  output logic              pin_oe_n
);

  logic         inhibit;
  logic         armed;
  logic         clear_flag;
  logic [W-1:0] next_value;
  logic         next_inhibit;
  logic         next_flag;
  logic         next_armed;
  logic         next_pending;
  logic         next_pin;

  always_comb begin
    match = tick && !inhibit && (count_next == value);
    clear_flag = acc_low && armed;
    next_value = value;
    if (wr_high) begin
      next_value = {wdata, value[7:0]};
    end else if (wr_low) begin
      next_value = {value[W-1:8], wdata};
    end
    next_inhibit = wr_high ? 1'b1 : (wr_low ? 1'b0 : inhibit);
    // A match in the clearing cycle keeps the flag set
    next_flag = match || (flag && !clear_flag);
    next_armed = armed;
    if (status_rd && flag) begin
      next_armed = 1'b1;
    end else if (clear_flag) begin
      next_armed = 1'b0;
    end
    next_pending = match ||
      (pending && !((status_acc && flag) || acc_low));
    next_pin = (match && pin_en) ? level : pin_out;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value   <= CNT_RST;
      inhibit <= 1'b0;
      flag    <= 1'b0;
      armed   <= 1'b0;
      pending <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      value   <= next_value;
      inhibit <= next_inhibit;
      flag    <= next_flag;
      armed   <= next_armed;
      pending <= next_pending;
      pin_out <= next_pin;
    end
  end

  // Pin released to general I/O while the pin enable is clear
  assign pin_oe_n = !pin_en;

  sequence s_arm;
    status_rd && flag && !match;
  endsequence
  sequence s_gap;
    !acc_low && !match;
  endsequence
  sequence s_clear;
    acc_low && !match && !status_rd;
  endsequence
  sequence s_high_idle;
    wr_high ##1 (!wr_low)[*2];
  endsequence

  a_flag_clear_seq: assert property (@(posedge clk) disable iff (!rst_n)
    s_arm ##1 s_gap ##1 s_clear |=> !flag)
    else $error("compare flag not cleared by status read then low access");
  a_pin_takes_level: assert property (@(posedge clk) disable iff (!rst_n)
    match && pin_en |=> pin_out == $past(level))
    else $error("compare pin did not take the output level");
  a_pending_drop: assert property (@(posedge clk) disable iff (!rst_n)
    acc_low && !match |=> !pending)
    else $error("compare request not withdrawn on low byte access");
  a_high_inhibits: assert property (@(posedge clk) disable iff (!rst_n)
    s_high_idle |-> !match)
    else $error("compare matched while high byte write pending");
  a_pin_gpio_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !pin_en |=> $stable(pin_out))
    else $error("compare pin changed while pin enable clear");

endmodule // compare_channel

// File: rtl/timer_compare_capture_unit.sv
// Timer compare/capture unit: 16-bit free-running counter, prescaler,
// two compare channels, two capture inputs and an 8-bit register port.
// Assumes pins are synchronous to clk; read data follow a read by a cycle.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module timer_compare_capture_unit import tcc_pkg::*; #(
  parameter int W = CNT_W
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire reg_req_t   req,
  output logic [7:0]      rdata,
  // Timer pins
  input  wire logic       capture1_input_pin,
  input  wire logic       capture2_input_pin,
  input  wire logic       ext_clock_input_pin,
  output logic [1:0]      compare_output_pin,
  output logic [1:0]      compare_output_pin_oe_n,
  // Interrupts
  output logic            compare_irq,
  output logic            irq
);

  irq_ctrl_t         ctrl;
  ctrl3_t            timer_control_three;
  logic [2:0]        pre;
  logic [W-1:0]      count;
  logic [W-1:0]      count_inc;
  logic [W-1:0]      capture1_value;
  logic [W-1:0]      capture2_value;
  logic [2:0]        pin_prev;
  logic [SF_N-1:0]   sflag;
  logic [SF_N-1:0]   sarmed;
  logic [EV_W-1:0]   ev_stat;
  logic [EV_W-1:0]   ev_mask;
  logic [7:0]        timer_flag_status;
  logic [W-1:0]      cmp_value [2];
  logic [1:0]        cmp_flag;
  logic [1:0]        cmp_pending;
  logic [1:0]        cmp_match;
  logic [2:0]        pre_mask;
  logic              tick;
  logic              ext_edge;
  logic              cap1_edge;
  logic              cap2_edge;
  logic              ovf_event;
  logic              status_rd;
  logic              status_acc;
  logic [SF_N-1:0]   sset;
  logic [SF_N-1:0]   sacc;
  irq_ctrl_t         next_ctrl;
  ctrl3_t            next_ctrl3;
  logic [2:0]        next_pre;
  logic [W-1:0]      next_count;
  logic [W-1:0]      next_cap1;
  logic [W-1:0]      next_cap2;
  logic [SF_N-1:0]   next_sflag;
  logic [SF_N-1:0]   next_sarmed;
  logic [EV_W-1:0]   next_ev_stat;
  logic [EV_W-1:0]   next_ev_mask;
  logic [EV_W-1:0]   ev_set;
  logic [7:0]        next_rdata;
  logic [1:0]        cmp_wr_hi;
  logic [1:0]        cmp_wr_lo;
  logic [1:0]        cmp_acc_lo;

  function automatic logic hit(input logic [7:0] ofs);
    hit = (req.rd || req.wr) && (req.addr == ofs);
  endfunction

  function automatic logic edge_of(input logic cur, input logic prev,
                                   input logic rising);
    edge_of = rising ? (cur && !prev) : (!cur && prev);
  endfunction

  // Timebase: prescaler, external edge and counter
  always_comb begin
    unique case (timer_control_three.timer_clock_select)
      CLK_DIV2: pre_mask = PRE_MASK_DIV2;
      CLK_DIV4: pre_mask = PRE_MASK_DIV4;
      CLK_DIV8: pre_mask = PRE_MASK_DIV8;
      CLK_EXT:  pre_mask = PRE_MASK_DIV8;
    endcase
    ext_edge = edge_of(ext_clock_input_pin, pin_prev[2],
                       timer_control_three.ext_clock_edge_select);
    if (timer_control_three.timer_clock_select == CLK_EXT) begin
      tick = ext_edge;
    end else begin
      tick = (pre & pre_mask) == pre_mask;
    end
    next_pre   = pre + 3'h1;
    count_inc  = count + W'(1);
    next_count = tick ? count_inc : count;
    ovf_event  = tick && (count == CNT_MAX);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre   <= 3'h0;
      count <= CNT_RST;
    end else begin
      pre   <= next_pre;
      count <= next_count;
    end
  end

  // Captures and the status flags that share one clearing scheme
  always_comb begin
    cap1_edge = edge_of(capture1_input_pin, pin_prev[0],
                        timer_control_three.capture1_edge_select);
    cap2_edge = edge_of(capture2_input_pin, pin_prev[1],
                        timer_control_three.capture2_edge_select);
    next_cap1 = cap1_edge ? count : capture1_value;
    next_cap2 = cap2_edge ? count : capture2_value;
    status_rd  = req.rd && (req.addr == OFS_STATUS);
    status_acc = hit(OFS_STATUS);
    // Decoded here so the channel ports follow every bus change
    cmp_wr_hi[0]  = req.wr && (req.addr == OFS_CMP1_HI);
    cmp_wr_hi[1]  = req.wr && (req.addr == OFS_CMP2_HI);
    cmp_wr_lo[0]  = req.wr && (req.addr == OFS_CMP1_LO);
    cmp_wr_lo[1]  = req.wr && (req.addr == OFS_CMP2_LO);
    cmp_acc_lo[0] = hit(OFS_CMP1_LO);
    cmp_acc_lo[1] = hit(OFS_CMP2_LO);
    sset[SF_CAP1] = cap1_edge;
    sset[SF_CAP2] = cap2_edge;
    sset[SF_OVF]  = ovf_event;
    sacc[SF_CAP1] = hit(OFS_CAP1_LO);
    sacc[SF_CAP2] = hit(OFS_CAP2_LO);
    sacc[SF_OVF]  = hit(OFS_CNT_LO);
    for (int i = 0; i < SF_N; i++) begin
      // New event beats a clear in the same cycle
      next_sflag[i] = sset[i] ||
        (sflag[i] && !(sacc[i] && sarmed[i]));
      next_sarmed[i] = sarmed[i];
      if (status_rd && sflag[i]) begin
        next_sarmed[i] = 1'b1;
      end else if (sacc[i] && sarmed[i]) begin
        next_sarmed[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capture1_value <= CNT_RST;
      capture2_value <= CNT_RST;
      pin_prev       <= 3'h0;
      sflag          <= '0;
      sarmed         <= '0;
    end else begin
      capture1_value <= next_cap1;
      capture2_value <= next_cap2;
      pin_prev       <= {ext_clock_input_pin, capture2_input_pin,
                         capture1_input_pin};
      sflag          <= next_sflag;
      sarmed         <= next_sarmed;
    end
  end

  // Compare channels
  compare_channel #(.W(W)) u_cmp1 (
    .clk        (clk),
    .rst_n      (rst_n),
    .tick       (tick),
    .count_next (count_inc),
    .wr_high    (cmp_wr_hi[0]),
    .wr_low     (cmp_wr_lo[0]),
    .acc_low    (cmp_acc_lo[0]),
    .status_rd  (status_rd),
    .status_acc (status_acc),
    .wdata      (req.wdata),
    .level      (ctrl.output_level1),
    .pin_en     (ctrl.pin_enable1),
    .value      (cmp_value[0]),
    .flag       (cmp_flag[0]),
    .pending    (cmp_pending[0]),
    .match      (cmp_match[0]),
    .pin_out    (compare_output_pin[0]),
    .pin_oe_n   (compare_output_pin_oe_n[0])
  );

  compare_channel #(.W(W)) u_cmp2 (
    .clk        (clk),
    .rst_n      (rst_n),
    .tick       (tick),
    .count_next (count_inc),
    .wr_high    (cmp_wr_hi[1]),
    .wr_low     (cmp_wr_lo[1]),
    .acc_low    (cmp_acc_lo[1]),
    .status_rd  (status_rd),
    .status_acc (status_acc),
    .wdata      (req.wdata),
    .level      (ctrl.output_level2),
    .pin_en     (ctrl.pin_enable2),
    .value      (cmp_value[1]),
    .flag       (cmp_flag[1]),
    .pending    (cmp_pending[1]),
    .match      (cmp_match[1]),
    .pin_out    (compare_output_pin[1]),
    .pin_oe_n   (compare_output_pin_oe_n[1])
  );

  // Timer compare request: the common enable overrides channel enables
  always_comb begin
    if (ctrl.common_compare_irq_enable) begin
      compare_irq = ctrl.timer_global_irq_enable &&
                    (|cmp_pending);
    end else begin
      compare_irq = ctrl.timer_global_irq_enable &&
        ((ctrl.channel1_compare_irq_enable && cmp_pending[0]) ||
         (ctrl.channel2_compare_irq_enable && cmp_pending[1]));
    end
  end

  // Registers, event status and read data
  always_comb begin
    timer_flag_status = STATUS_RST;
    timer_flag_status[FLAG_CAP1] = sflag[SF_CAP1];
    timer_flag_status[FLAG_CMP1] = cmp_flag[0];
    timer_flag_status[FLAG_OVF]  = sflag[SF_OVF];
    timer_flag_status[FLAG_CAP2] = sflag[SF_CAP2];
    timer_flag_status[FLAG_CMP2] = cmp_flag[1];
    ev_set = '0;
    ev_set[EV_CMP1] = cmp_match[0];
    ev_set[EV_CMP2] = cmp_match[1];
    ev_set[EV_CAP1] = cap1_edge;
    ev_set[EV_CAP2] = cap2_edge;
    ev_set[EV_OVF]  = ovf_event;
    next_ev_stat = ev_stat;
    if (req.wr && req.addr == OFS_EV_STAT) begin
      next_ev_stat = ev_stat & ~req.wdata[EV_W-1:0];
    end
    next_ev_stat = next_ev_stat | ev_set;
    next_ev_mask = (req.wr && req.addr == OFS_EV_MASK) ?
                   req.wdata[EV_W-1:0] : ev_mask;
    next_ctrl  = (req.wr && req.addr == OFS_IRQ_CTRL) ?
                 irq_ctrl_t'(req.wdata) : ctrl;
    next_ctrl3 = (req.wr && req.addr == OFS_CTRL3) ?
                 ctrl3_t'(req.wdata) : timer_control_three;
    next_rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        OFS_CAP1_HI:  next_rdata = capture1_value[W-1:8];
        OFS_CAP1_LO:  next_rdata = capture1_value[7:0];
        OFS_CAP2_HI:  next_rdata = capture2_value[W-1:8];
        OFS_CAP2_LO:  next_rdata = capture2_value[7:0];
        OFS_CMP1_HI:  next_rdata = cmp_value[0][W-1:8];
        OFS_CMP1_LO:  next_rdata = cmp_value[0][7:0];
        OFS_CMP2_HI:  next_rdata = cmp_value[1][W-1:8];
        OFS_CMP2_LO:  next_rdata = cmp_value[1][7:0];
        OFS_CNT_HI:   next_rdata = count[W-1:8];
        OFS_CNT_LO:   next_rdata = count[7:0];
        OFS_IRQ_CTRL: next_rdata = ctrl;
        OFS_CTRL3:    next_rdata = timer_control_three;
        OFS_EV_STAT:  next_rdata = {3'h0, ev_stat};
        OFS_EV_MASK:  next_rdata = {3'h0, ev_mask};
        OFS_STATUS:   next_rdata = timer_flag_status;
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl                <= irq_ctrl_t'(CTRL_RST);
      timer_control_three <= ctrl3_t'(CTRL_RST);
      ev_stat             <= EV_RST;
      ev_mask             <= EV_RST;
      rdata               <= 8'h00;
    end else begin
      ctrl                <= next_ctrl;
      timer_control_three <= next_ctrl3;
      ev_stat             <= next_ev_stat;
      ev_mask             <= next_ev_mask;
      rdata               <= next_rdata;
    end
  end

  assign irq = |(ev_stat & ev_mask);

  sequence s_div8_gap;
    (tick && timer_control_three.timer_clock_select == CLK_DIV8) ##1
    (!tick && timer_control_three.timer_clock_select == CLK_DIV8)[*7];
  endsequence

  a_common_irq: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.common_compare_irq_enable && ctrl.timer_global_irq_enable &&
    (|cmp_pending) |-> compare_irq)
    else $error("compare interrupt missing with common enable set");
  a_channel_irq: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl.common_compare_irq_enable &&
    !(ctrl.channel1_compare_irq_enable && cmp_pending[0]) &&
    !(ctrl.channel2_compare_irq_enable && cmp_pending[1])
    |-> !compare_irq)
    else $error("compare interrupt raised without channel enable");
  a_div8_period: assert property (@(posedge clk) disable iff (!rst_n)
    s_div8_gap |=> tick)
    else $error("divide by 8 tick spacing wrong");
  a_cap2_edge: assert property (@(posedge clk) disable iff (!rst_n)
    timer_control_three.capture2_edge_select && capture2_input_pin &&
    !pin_prev[1] |=> sflag[SF_CAP2] && capture2_value == $past(count))
    else $error("capture 2 missed a rising edge");
  a_ext_count: assert property (@(posedge clk) disable iff (!rst_n)
    timer_control_three.timer_clock_select == CLK_EXT &&
    !timer_control_three.ext_clock_edge_select &&
    !ext_clock_input_pin && pin_prev[2] |=> count == $past(count_inc))
    else $error("external falling edge did not advance counter");
  a_status_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
    status_rd |=> rdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_cap1_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (status_rd && sflag[SF_CAP1] && !cap1_edge) ##1
    (!sacc[SF_CAP1] && !cap1_edge) ##1
    (sacc[SF_CAP1] && !cap1_edge && !status_rd) |=> !sflag[SF_CAP1])
    else $error("capture 1 flag not cleared");
  a_overflow_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    ovf_event |=> sflag[SF_OVF] && count == CNT_RST)
    else $error("overflow not flagged on wrap");

endmodule // timer_compare_capture_unit

// File: dv/timer_pins_model.sv
// Model of the pins facing the timer: capture inputs and external clock.
// Assumes the bench calls its tasks; pins hold level between calls.
`timescale 1ns/1ps
module timer_pins_model (
  // Clock
  input  wire logic clk,
  // Pins toward the timer
  output logic      cap1,
  output logic      cap2,
  output logic      ext
);
  initial begin
    cap1 = 1'b0;
    cap2 = 1'b0;
    ext  = 1'b0;
  end

  // Both capture pins move together, then settle for two cycles
  task automatic set_caps(input logic v);
    @(posedge clk);
    cap1 <= v;
    cap2 <= v;
    repeat (2) @(posedge clk);
  endtask

  // Each level is held two cycles so no edge is lost by the sampler
  task automatic toggle_ext(input int n);
    repeat (n) begin
      @(posedge clk);
      ext <= ~ext;
      @(posedge clk);
    end
    @(posedge clk);
  endtask
endmodule // timer_pins_model

// File: dv/timer_compare_capture_unit_test.sv
// Self-checking bench for the timer compare/capture unit.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
module timer_compare_capture_unit_test;
  import tcc_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  reg_req_t   req = '0;
  logic [7:0] rdata, v, c0;
  logic [1:0] pin, oe_n;
  logic       cirq, irq, cap1, cap2, ext;
  int         n_fail = 0;
  int         checks_done = 0;

  always #5 clk = ~clk;

  timer_compare_capture_unit timer_compare_capture_unit_i (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .capture1_input_pin(cap1), .capture2_input_pin(cap2),
    .ext_clock_input_pin(ext), .compare_output_pin(pin),
    .compare_output_pin_oe_n(oe_n), .compare_irq(cirq), .irq(irq));
  timer_pins_model timer_pins_model_i (
    .clk(clk), .cap1(cap1), .cap2(cap2), .ext(ext));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic t_reset;
    rdchk(OFS_STATUS, 8'h00);
    chk({6'h0, pin}, 8'h00);
    wr(OFS_STATUS, 8'hFF);
    rdchk(OFS_STATUS, 8'h00);
    rdchk(8'h10, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_compare;
    wr(OFS_IRQ_CTRL, 8'h9A);
    wr(OFS_CTRL3, 8'h04);
    wr(OFS_CMP1_HI, 8'h00);
    rd(OFS_STATUS, v);
    wr(OFS_CMP1_LO, 8'h40);
    repeat (150) @(posedge clk);
    chk({6'h0, pin}, 8'h01);
    chk({6'h0, oe_n}, 8'h02);
    chk({7'h0, cirq}, 8'h01);
    rdchk(OFS_STATUS, 8'h40);
    chk({7'h0, cirq}, 8'h00);
    rdchk(OFS_CMP1_LO, 8'h40);
    rdchk(OFS_STATUS, 8'h00);
    $display("test compare done");
  endtask

  task automatic t_inhibit;
    wr(OFS_CMP1_HI, 8'h01);
    repeat (600) @(posedge clk);
    rdchk(OFS_STATUS, 8'h00);
    wr(OFS_IRQ_CTRL, 8'h90);
    chk({6'h0, oe_n}, 8'h03);
    wr(OFS_CMP1_HI, 8'h02);
    rd(OFS_STATUS, v);
    wr(OFS_CMP1_LO, 8'h40);
    repeat (450) @(posedge clk);
    chk({7'h0, cirq}, 8'h01);
    chk({6'h0, pin}, 8'h01);
    wr(OFS_IRQ_CTRL, 8'h10);
    chk({7'h0, cirq}, 8'h00);
    wr(OFS_IRQ_CTRL, 8'h50);
    chk({7'h0, cirq}, 8'h01);
    wr(OFS_IRQ_CTRL, 8'h40);
    chk({7'h0, cirq}, 8'h00);
    rdchk(OFS_STATUS, 8'h40);
    wr(OFS_CMP1_LO, 8'h40);
    rdchk(OFS_STATUS, 8'h00);
    $display("test inhibit done");
  endtask

  task automatic t_ext;
    wr(OFS_CTRL3, 8'h0D);
    rd(OFS_CNT_LO, c0);
    timer_pins_model_i.toggle_ext(3);
    rdchk(OFS_CNT_LO, c0 + 8'h02);
    wr(OFS_CTRL3, 8'h0C);
    rd(OFS_CNT_LO, c0);
    timer_pins_model_i.toggle_ext(3);
    rdchk(OFS_CNT_LO, c0 + 8'h02);
    $display("test external clock done");
  endtask

  task automatic t_capture;
    wr(OFS_EV_STAT, 8'h1F);
    timer_pins_model_i.set_caps(1'b1);
    rdchk(OFS_STATUS, 8'h00);
    timer_pins_model_i.set_caps(1'b0);
    rdchk(OFS_STATUS, 8'h90);
    rdchk(OFS_CAP1_LO, c0 + 8'h02);
    rdchk(OFS_CAP2_LO, c0 + 8'h02);
    rdchk(OFS_STATUS, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(OFS_EV_MASK, 8'h04);
    chk({7'h0, irq}, 8'h01);
    wr(OFS_EV_STAT, 8'h04);
    chk({7'h0, irq}, 8'h00);
    rdchk(OFS_EV_STAT, 8'h08);
    wr(OFS_CTRL3, 8'h0E);
    timer_pins_model_i.set_caps(1'b1);
    rdchk(OFS_STATUS, 8'h10);
    rdchk(OFS_CAP2_LO, c0 + 8'h02);
    $display("test capture done");
  endtask

  // Reads 64 cycles apart, so the tick phase cannot change the step count
  task automatic t_prescale;
    wr(OFS_CTRL3, 8'h00);
    rd(OFS_CNT_LO, c0);
    repeat (62) @(posedge clk);
    rdchk(OFS_CNT_LO, c0 + 8'h10);
    wr(OFS_CTRL3, 8'h08);
    rd(OFS_CNT_LO, c0);
    repeat (62) @(posedge clk);
    rdchk(OFS_CNT_LO, c0 + 8'h08);
    $display("test prescaler done");
  endtask

  task automatic t_mid_reset;
    chk({6'h0, pin}, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({6'h0, pin}, 8'h00);
    chk({6'h0, oe_n}, 8'h03);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(OFS_STATUS, 8'h00);
    rdchk(OFS_CTRL3, 8'h00);
    chk({7'h0, cirq}, 8'h00);
    chk({6'h0, pin}, 8'h00);
    $display("test mid-run reset done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_compare;
    t_inhibit;
    t_ext;
    t_capture;
    t_prescale;
    t_mid_reset;
    print_verdict;
  end

  // Whole run needs about 1500 cycles; allow far more before cutting it
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule // timer_compare_capture_unit_test
